// ==== rtl/mdh_regs.svh ====
// constants of the microcode download handler: opcodes, subcommands, flag bits, sizes
// assumes inclusion by bare name from the package and the design modules
// Operation
// - opcode 92h selects the microcode download handler
// - feature 03h offset mode, 07h single transfer
// - sector count: lba low high, count low
// - host sends whole sectors only, never partial
// - abort on reserved feature or security lock
// - failed requested reload sets uncorrectable flag
// - spin down after reload when spin-up disabled
// - offset mode offset: lba high and mid
// - host sends offset segments in ascending order
// - first offset segment starts at offset zero
// - offset mismatch aborts and discards gathered image
// - final segment: verify then store whole image
// - new firmware active after final transfer ends
// - other command executes and drops partial image
// - reset drops partial image, then resets
// - payload is opaque, passed on uninterpreted
`ifndef MDH_REGS_SVH
`define MDH_REGS_SVH
`define MDH_OP_DOWNLOAD 8'h92
`define MDH_SUB_OFFSET 8'h03
`define MDH_SUB_SINGLE 8'h07
`define MDH_SECTOR_PAD 8'h00
`define MDH_WORD_W 16
`define MDH_FIFO_DEPTH 16
`define MDH_ERR_ABT 2
`define MDH_ERR_UNC 6
`define MDH_ST_BSY 7
`define MDH_ST_RDY 6
`define MDH_ST_DF 5
`define MDH_ST_DSC 4
`define MDH_ST_DRQ 3
`define MDH_ST_ERR 0
`define MDH_ERR_RESET 8'h00
`define MDH_ST_RESET 8'h50
`define MDH_OFF_ZERO 16'h0000
`define MDH_WORDS_ZERO 24'h000000
`define MDH_WORDS_ONE 24'h000001
`endif

// ==== rtl/mdh_pkg.sv ====
// types shared by both ends of the microcode download handler
// assumes mdh_regs.svh is on the include path
`include "mdh_regs.svh"
package mdh_pkg;
   typedef enum logic [1:0] {
      MDH_D_IDLE = 2'b00,
      MDH_D_DATA = 2'b01,
      MDH_D_END = 2'b10
   } mdh_dev_state_t;
   typedef enum logic [1:0] {
      MDH_H_IDLE = 2'b00,
      MDH_H_CMD = 2'b01,
      MDH_H_DATA = 2'b10,
      MDH_H_WAIT = 2'b11
   } mdh_host_state_t;
   typedef struct packed {
      mdh_dev_state_t state;
      logic cmd_ready;
      logic [15:0] expected_off;
      logic [15:0] count;
      logic [23:0] words_left;
      logic final_seg;
      logic [7:0] error;
      logic [7:0] status;
      logic done;
      logic commit;
      logic discard;
      logic spin_down;
      logic fw_active;
      logic other_valid;
      logic [7:0] other_code;
   } mdh_dev_s_t;
   typedef struct packed {
      mdh_host_state_t state;
      logic cmd_valid;
      logic [7:0] code;
      logic [7:0] feature;
      logic [15:0] count;
      logic [15:0] offset;
      logic [15:0] seg_off;
      logic [23:0] words_left;
      logic dvalid;
      logic [15:0] dword;
      logic soft_reset;
      logic res_done;
      logic [7:0] res_status;
      logic [7:0] res_error;
   } mdh_host_s_t;
endpackage

// ==== rtl/mdh_if.sv ====
// command block, data stream and completion between host adapter and device handler
// assumes both ends share clk and sys_rst
`timescale 1ns/10ps
`default_nettype none
interface mdh_if;
   logic cmd_valid;
   logic cmd_ready;
   logic [7:0] cmd_code;
   logic [7:0] feature;
   logic [7:0] sector_count;
   logic [7:0] lba_low;
   logic [7:0] lba_mid;
   logic [7:0] lba_high;
   logic data_valid;
   logic data_ready;
   logic [15:0] data;
   logic done;
   logic [7:0] status;
   logic [7:0] error;
   logic soft_reset;
   modport dev (input cmd_valid, cmd_code, feature, sector_count, lba_low, lba_mid, lba_high,
                input data_valid, data, soft_reset,
                output cmd_ready, data_ready, done, status, error);
   modport host (output cmd_valid, cmd_code, feature, sector_count, lba_low, lba_mid, lba_high,
                 output data_valid, data, soft_reset,
                 input cmd_ready, data_ready, done, status, error);
endinterface
`default_nettype wire

// ==== rtl/mdh_device.sv ====
// device end: download command decode, segment check, image buffering and commit
// assumes one clock, synchronous reset, user-side inputs from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "mdh_regs.svh"
module mdh_fifo
   import mdh_pkg::*;
#(
   parameter int WIDTH = `MDH_WORD_W,
   parameter int DEPTH = `MDH_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] used;
   } mdh_fifo_s_t;
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
   logic [WIDTH-1:0] mem [DEPTH];
   mdh_fifo_s_t r_reg, r_next;
   logic push, pop;
   assign in_ready = (r_reg.used != FULL_COUNT);
   assign out_valid = (r_reg.used != '0);
   assign out_data = mem[r_reg.rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_comb begin
      r_next = r_reg;
      if (push) begin
         r_next.wr_ptr = (r_reg.wr_ptr == LAST_PTR) ? '0 : r_reg.wr_ptr + 1'b1;
      end
      if (pop) begin
         r_next.rd_ptr = (r_reg.rd_ptr == LAST_PTR) ? '0 : r_reg.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         r_next.used = r_reg.used + 1'b1;
      end else if (pop && !push) begin
         r_next.used = r_reg.used - 1'b1;
      end
      // flush wins: a dropped image must not leak a stale word
      if (flush) begin
         r_next = '0;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
   always_ff @(posedge clk) begin
      if (push) begin
         mem[r_reg.wr_ptr] <= in_data;
      end
   end
endmodule

module mdh_device
   import mdh_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link to host adapter
   mdh_if.dev bus,
   // drive state
   input wire logic security_locked,
   input wire logic spinup_disabled,
   input wire logic [15:0] image_sectors,
   // reload outcome, sampled in the cycle before commit pulses
   input wire logic reload_requested,
   input wire logic reload_ok,
   // image store side
   output logic img_valid,
   input wire logic img_ready,
   output logic [15:0] img_data,
   output logic commit,
   output logic discard,
   output logic spin_down,
   output logic fw_active,
   // other commands passed on for execution
   output logic other_valid,
   output logic [7:0] other_code,
   // flags
   output logic [7:0] command_error_flags,
   output logic [7:0] command_status_flags
);
   mdh_dev_s_t r_reg, r_next;
   logic fifo_in_ready;
   logic push;
   logic [15:0] cmd_count;
   logic [15:0] cmd_off;
   logic [7:0] st_ok;
   logic [7:0] st_err;

   assign cmd_count = {bus.lba_low, bus.sector_count};
   assign cmd_off = {bus.lba_high, bus.lba_mid};
   assign push = bus.data_valid && fifo_in_ready && (r_reg.state == MDH_D_DATA);
   assign bus.data_ready = fifo_in_ready && (r_reg.state == MDH_D_DATA);

   // payload goes out untouched, the store owns its format
   mdh_fifo #(.WIDTH(`MDH_WORD_W), .DEPTH(`MDH_FIFO_DEPTH)) mdh_fifo_inst (
      .clk(clk),
      .sys_rst(sys_rst),
      .flush(r_reg.discard),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(bus.data),
      .out_valid(img_valid),
      .out_ready(img_ready),
      .out_data(img_data)
   );

   always_comb begin
      st_ok = '0;
      st_ok[`MDH_ST_RDY] = 1'b1;
      st_ok[`MDH_ST_DSC] = 1'b1;
      st_err = st_ok;
      st_err[`MDH_ST_ERR] = 1'b1;
      r_next = r_reg;
      r_next.done = 1'b0;
      r_next.commit = 1'b0;
      r_next.discard = 1'b0;
      r_next.spin_down = 1'b0;
      r_next.other_valid = 1'b0;
      case (r_reg.state)
         MDH_D_IDLE: begin
            r_next.cmd_ready = 1'b1;
            if (bus.cmd_valid && r_reg.cmd_ready) begin
               r_next.cmd_ready = 1'b0;
               r_next.error = `MDH_ERR_RESET;
               if (bus.cmd_code != `MDH_OP_DOWNLOAD) begin
                  r_next.other_valid = 1'b1;
                  r_next.other_code = bus.cmd_code;
                  r_next.discard = (r_reg.expected_off != `MDH_OFF_ZERO);
                  r_next.expected_off = `MDH_OFF_ZERO;
                  r_next.status = st_ok;
                  r_next.done = 1'b1;
               end else if (((bus.feature != `MDH_SUB_OFFSET) && (bus.feature != `MDH_SUB_SINGLE))
                            || security_locked) begin
                  r_next.error[`MDH_ERR_ABT] = 1'b1;
                  r_next.status = st_err;
                  r_next.done = 1'b1;
               end else if ((bus.feature == `MDH_SUB_OFFSET) && (cmd_off != r_reg.expected_off)) begin
                  r_next.error[`MDH_ERR_ABT] = 1'b1;
                  r_next.status = st_err;
                  r_next.discard = 1'b1;
                  r_next.expected_off = `MDH_OFF_ZERO;
                  r_next.done = 1'b1;
               end else begin
                  r_next.count = cmd_count;
                  r_next.words_left = {cmd_count, `MDH_SECTOR_PAD};
                  r_next.final_seg = (bus.feature == `MDH_SUB_SINGLE) ||
                                     (16'(cmd_off + cmd_count) == image_sectors);
                  r_next.status = '0;
                  r_next.status[`MDH_ST_BSY] = 1'b1;
                  r_next.status[`MDH_ST_DRQ] = 1'b1;
                  // a zero length segment has no data phase to wait for
                  r_next.state = (cmd_count == `MDH_OFF_ZERO) ? MDH_D_END : MDH_D_DATA;
               end
            end
         end
         MDH_D_DATA: begin
            if (push) begin
               r_next.words_left = r_reg.words_left - `MDH_WORDS_ONE;
               if (r_reg.words_left == `MDH_WORDS_ONE) begin
                  r_next.state = MDH_D_END;
               end
            end
         end
         MDH_D_END: begin
            r_next.state = MDH_D_IDLE;
            r_next.done = 1'b1;
            r_next.status = st_ok;
            if (r_reg.final_seg) begin
               // the store verifies and saves on commit
               r_next.commit = 1'b1;
               r_next.expected_off = `MDH_OFF_ZERO;
               if (reload_requested && !reload_ok) begin
                  r_next.error[`MDH_ERR_UNC] = 1'b1;
                  r_next.status = st_err;
               end else begin
                  r_next.fw_active = 1'b1;
               end
               r_next.spin_down = reload_requested && spinup_disabled;
            end else begin
               r_next.expected_off = 16'(r_reg.expected_off + r_reg.count);
            end
         end
         default: begin
            r_next.state = MDH_D_IDLE;
         end
      endcase
      // reset from the link overrides any command in flight but the spin_down and fw_active of a final MDH_D_END cycle
      if (bus.soft_reset) begin
         r_next.discard = (r_reg.expected_off != `MDH_OFF_ZERO) || (r_reg.state != MDH_D_IDLE);
         r_next.expected_off = `MDH_OFF_ZERO;
         r_next.state = MDH_D_IDLE;
         r_next.cmd_ready = 1'b0;
         r_next.error = `MDH_ERR_RESET;
         r_next.status = `MDH_ST_RESET;
         r_next.done = 1'b0;
         r_next.commit = 1'b0;
         r_next.other_valid = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_reg <= '0;
         r_reg.status <= `MDH_ST_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign bus.cmd_ready = r_reg.cmd_ready;
   assign bus.done = r_reg.done;
   assign bus.status = r_reg.status;
   assign bus.error = r_reg.error;
   assign commit = r_reg.commit;
   assign discard = r_reg.discard;
   assign spin_down = r_reg.spin_down;
   assign fw_active = r_reg.fw_active;
   assign other_valid = r_reg.other_valid;
   assign other_code = r_reg.other_code;
   assign command_error_flags = r_reg.error;
   assign command_status_flags = r_reg.status;
endmodule
`default_nettype wire

// ==== rtl/mdh_host.sv ====
// host end: issues commands, generates segment offsets, streams whole sectors
// assumes one clock, synchronous reset, user side on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "mdh_regs.svh"
module mdh_host
   import mdh_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link to device
   mdh_if.host bus,
   // command requests
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [7:0] req_code,
   input wire logic [7:0] req_feature,
   input wire logic [15:0] req_count,
   input wire logic req_first,
   input wire logic reset_req,
   // payload words
   input wire logic wdata_valid,
   output logic wdata_ready,
   input wire logic [15:0] wdata,
   // results
   output logic res_done,
   output logic [7:0] res_status,
   output logic [7:0] res_error
);
   mdh_host_s_t r_reg, r_next;
   logic is_dl;
   logic [15:0] off_now;

   assign is_dl = (req_code == `MDH_OP_DOWNLOAD) &&
                  ((req_feature == `MDH_SUB_OFFSET) || (req_feature == `MDH_SUB_SINGLE));
   // offsets come from our own counter so segments cannot skip, or repeat except when req_first, an error, reset_req or a non-offset command restarts at zero
   assign off_now = req_first ? `MDH_OFF_ZERO : r_reg.seg_off;
   assign req_ready = (r_reg.state == MDH_H_IDLE) && !r_reg.soft_reset;
   assign wdata_ready = (r_reg.state == MDH_H_DATA) && (r_reg.words_left != `MDH_WORDS_ZERO) &&
                        (!r_reg.dvalid || bus.data_ready);

   always_comb begin
      r_next = r_reg;
      r_next.res_done = 1'b0;
      r_next.soft_reset = 1'b0;
      if (r_reg.dvalid && bus.data_ready) begin
         r_next.dvalid = 1'b0;
      end
      case (r_reg.state)
         MDH_H_IDLE: begin
            if (req_valid && req_ready) begin
               r_next.code = req_code;
               r_next.feature = req_feature;
               r_next.count = req_count;
               r_next.offset = (req_feature == `MDH_SUB_OFFSET) ? off_now : `MDH_OFF_ZERO;
               // whole sectors only, never a tail
               r_next.words_left = is_dl ? {req_count, `MDH_SECTOR_PAD} : `MDH_WORDS_ZERO;
               r_next.cmd_valid = 1'b1;
               r_next.state = MDH_H_CMD;
            end
         end
         MDH_H_CMD: begin
            if (bus.cmd_ready) begin
               r_next.cmd_valid = 1'b0;
               r_next.state = (r_reg.words_left != `MDH_WORDS_ZERO) ? MDH_H_DATA : MDH_H_WAIT;
            end
         end
         MDH_H_DATA: begin
            if (wdata_valid && wdata_ready) begin
               r_next.dvalid = 1'b1;
               r_next.dword = wdata;
               r_next.words_left = r_reg.words_left - `MDH_WORDS_ONE;
            end
         end
         MDH_H_WAIT: begin
         end
         default: begin
            r_next.state = MDH_H_IDLE;
         end
      endcase
      // device may finish early on abort, so done ends the data or wait phase
      if ((r_reg.state == MDH_H_DATA || r_reg.state == MDH_H_WAIT) && bus.done) begin
         r_next.state = MDH_H_IDLE;
         r_next.dvalid = 1'b0;
         r_next.res_done = 1'b1;
         r_next.res_status = bus.status;
         r_next.res_error = bus.error;
         if (r_reg.code == `MDH_OP_DOWNLOAD && r_reg.feature == `MDH_SUB_OFFSET && !bus.status[`MDH_ST_ERR]) begin
            r_next.seg_off = 16'(r_reg.offset + r_reg.count);
         end else begin
            r_next.seg_off = `MDH_OFF_ZERO;
         end
      end
      if (reset_req) begin
         r_next = '0;
         r_next.soft_reset = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign bus.cmd_valid = r_reg.cmd_valid;
   assign bus.cmd_code = r_reg.code;
   assign bus.feature = r_reg.feature;
   assign bus.sector_count = r_reg.count[7:0];
   assign bus.lba_low = r_reg.count[15:8];
   assign bus.lba_mid = r_reg.offset[7:0];
   assign bus.lba_high = r_reg.offset[15:8];
   assign bus.data_valid = r_reg.dvalid;
   assign bus.data = r_reg.dword;
   assign bus.soft_reset = r_reg.soft_reset;
   assign res_done = r_reg.res_done;
   assign res_status = r_reg.res_status;
   assign res_error = r_reg.res_error;
endmodule
`default_nettype wire

// ==== verification/mdh_chk.sv ====
// concurrent checks on the link between host end and device end
// assumes it is instantiated beside the link, one clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module mdh_chk (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // command block
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [7:0] cmd_code,
   input wire logic [7:0] feature,
   input wire logic [7:0] sector_count,
   input wire logic [7:0] lba_low,
   // data stream
   input wire logic data_valid,
   input wire logic data_ready,
   input wire logic [15:0] data,
   // results
   input wire logic done,
   input wire logic [7:0] status,
   input wire logic [7:0] error,
   input wire logic soft_reset
);
   logic take;
   logic dl_take;
   logic [23:0] exp_words_reg;
   logic [23:0] got_words_reg;
   assign take = cmd_valid && cmd_ready;
   assign dl_take = take && cmd_code == 8'h92 && (feature == 8'h03 || feature == 8'h07);
   // word tally per download; either reset drops it, as the image is dropped
   always_ff @(posedge clk) begin
      if (sys_rst || soft_reset) begin
         exp_words_reg <= 24'h000000;
         got_words_reg <= 24'h000000;
      end else if (take) begin
         exp_words_reg <= dl_take ? {lba_low, sector_count, 8'h00} : 24'h000000;
         got_words_reg <= 24'h000000;
      end else if (data_valid && data_ready) begin
         got_words_reg <= got_words_reg + 24'h000001;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   a_abort_reserved: assert property (
      take && cmd_code == 8'h92 && feature != 8'h03 && feature != 8'h07 |=> done && error == 8'h04 && status == 8'h51)
      else $error("reserved subcommand not aborted");
   a_download_busy: assert property (
      dl_take && {lba_low, sector_count} != 16'h0000 |=> status == 8'h88 || (done && error == 8'h04))
      else $error("download not started");
   a_other_cmd: assert property (
      take && cmd_code != 8'h92 |=> done && status == 8'h50 && error == 8'h00)
      else $error("other command not completed");
   a_err_bit: assert property (done |-> status[0] == (error[2] || error[6]))
      else $error("status error bit disagrees with flags");
   a_ok_status: assert property (done && !status[0] |-> status == 8'h50 && error == 8'h00)
      else $error("bad completion status");
   a_ready_gap: assert property (done |-> !cmd_ready ##1 cmd_ready)
      else $error("command ready not restored after done");
   a_soft_reset: assert property (
      soft_reset |=> status == 8'h50 && error == 8'h00 && !cmd_ready)
      else $error("soft reset did not return to idle");
   a_word_count: assert property (done && !error[2] |-> got_words_reg == exp_words_reg)
      else $error("word count differs from sector count");
   a_word_bound: assert property (
      data_valid && data_ready |-> got_words_reg < exp_words_reg && status == 8'h88)
      else $error("word taken outside a transfer");
   a_data_hold: assert property (data_valid && !data_ready |=> data_valid && $stable(data))
      else $error("data word dropped while stalled");
endmodule
`default_nettype wire

// ==== verification/microcode_download_handler_tb.sv ====
// self-checking bench: host end and device end joined by the link, driven from the user sides
// assumes the design files and mdh_chk are compiled first
`timescale 1ns/10ps
`default_nettype none
module microcode_download_handler_tb;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req_valid = 1'b0;
   logic [7:0] req_code = 8'h00;
   logic [7:0] req_feature = 8'h00;
   logic [15:0] req_count = 16'h0000;
   logic req_first = 1'b0;
   logic reset_req = 1'b0;
   logic wdata_valid = 1'b0;
   logic [15:0] wdata = 16'h0000;
   logic security_locked = 1'b0;
   logic spinup_disabled = 1'b0;
   logic [15:0] image_sectors = 16'h0003;
   logic reload_requested = 1'b1;
   logic reload_ok = 1'b1;
   logic img_ready = 1'b1;
   logic req_ready, wdata_ready, res_done, img_valid, commit, discard, spin_down, fw_active, other_valid;
   logic [7:0] res_status, res_error, other_code, dev_err, dev_st;
   logic [15:0] img_data;
   int num_errors = 0;
   int n_compared = 0;
   int n_img, n_sent, n_commit, n_discard, n_spin, n_other;
   mdh_if link ();
   mdh_host mdh_host_inst (.clk(clk), .sys_rst(sys_rst), .bus(link), .req_valid(req_valid), .req_ready(req_ready),
      .req_code(req_code), .req_feature(req_feature), .req_count(req_count), .req_first(req_first),
      .reset_req(reset_req), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata),
      .res_done(res_done), .res_status(res_status), .res_error(res_error));
   mdh_device mdh_device_inst (.clk(clk), .sys_rst(sys_rst), .bus(link), .security_locked(security_locked),
      .spinup_disabled(spinup_disabled), .image_sectors(image_sectors), .reload_requested(reload_requested),
      .reload_ok(reload_ok), .img_valid(img_valid), .img_ready(img_ready), .img_data(img_data), .commit(commit),
      .discard(discard), .spin_down(spin_down), .fw_active(fw_active), .other_valid(other_valid),
      .other_code(other_code), .command_error_flags(dev_err), .command_status_flags(dev_st));
   mdh_chk mdh_chk_inst (.clk(clk), .sys_rst(sys_rst), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
      .cmd_code(link.cmd_code), .feature(link.feature), .sector_count(link.sector_count), .lba_low(link.lba_low),
      .data_valid(link.data_valid), .data_ready(link.data_ready), .data(link.data), .done(link.done),
      .status(link.status), .error(link.error), .soft_reset(link.soft_reset));
   initial begin
      forever #50 clk = ~clk;
   end
   function automatic logic [15:0] pat(input int i);
      return 16'(i * 3) ^ 16'h5a3c;
   endfunction
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic tmo(input string what);
      num_errors++;
      $display("[ERR] %s expected handshake seen timeout", what);
      print_verdict();
   endtask
   // sink tally; payload must leave in the order it entered, untouched
   always @(posedge clk) begin
      if (!sys_rst) begin
         if (img_valid === 1'b1 && img_ready) begin
            chk("img_data", {8'h00, img_data}, {8'h00, pat(n_img)});
            n_img++;
         end
         if (commit === 1'b1) n_commit++;
         if (discard === 1'b1) n_discard++;
         if (spin_down === 1'b1) n_spin++;
         if (other_valid === 1'b1) n_other++;
      end
   end
   task automatic clr();
      n_img = 0;
      n_sent = 0;
      n_commit = 0;
      n_discard = 0;
      n_spin = 0;
      n_other = 0;
   endtask
   task automatic issue(input logic [7:0] code, input logic [7:0] feat, input logic [15:0] cnt, input logic first);
      int g;
      g = 0;
      while (req_ready !== 1'b1 && g < 100) begin
         @(negedge clk);
         g++;
      end
      if (g == 100) tmo("req_ready");
      req_valid = 1'b1;
      req_code = code;
      req_feature = feat;
      req_count = cnt;
      req_first = first;
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   task automatic wait_done(input int lim);
      int g;
      g = 0;
      while (res_done !== 1'b1 && g < lim) begin
         @(negedge clk);
         g++;
      end
      if (g == lim) tmo("res_done");
      @(negedge clk);
   endtask
   // whole sectors only: callers pass count times 256
   task automatic feed(input int n);
      int g;
      for (int i = 0; i < n; i++) begin
         wdata_valid = 1'b1;
         wdata = pat(n_sent);
         g = 0;
         while (wdata_ready !== 1'b1 && g < 1000) begin
            @(negedge clk);
            g++;
         end
         if (g == 1000) tmo("wdata_ready");
         @(negedge clk);
         n_sent++;
      end
      wdata_valid = 1'b0;
   endtask
   task automatic seg(input logic [15:0] cnt, input logic first);
      issue(8'h92, 8'h03, cnt, first);
      feed(int'(cnt) * 256);
      wait_done(100);
      chk("seg_status", {16'h0, res_status}, 24'h000050);
   endtask
   task automatic t_abort();
      logic [7:0] feats [5] = '{8'h00, 8'h01, 8'h05, 8'h08, 8'hff};
      foreach (feats[i]) begin
         issue(8'h92, feats[i], 16'h0001, 1'b1);
         wait_done(50);
         chk("abort_err", {16'h0, res_error}, 24'h000004);
         chk("abort_status", {16'h0, res_status}, 24'h000051);
      end
      security_locked = 1'b1;
      issue(8'h92, 8'h07, 16'h0001, 1'b1);
      wait_done(50);
      chk("locked_err", {16'h0, res_error}, 24'h000004);
      security_locked = 1'b0;
      $display("test abort done");
   endtask
   // big count crosses the byte boundary; sink stalls until the buffer refuses
   task automatic t_single();
      clr();
      img_ready = 1'b0;
      issue(8'h92, 8'h07, 16'h0102, 1'b0);
      fork
         feed(66048);
      join_none
      repeat (60) @(negedge clk);
      chk("full_ready", {23'h0, link.data_ready}, 24'h000000);
      chk("early_fw", {23'h0, fw_active}, 24'h000000);
      img_ready = 1'b1;
      wait fork;
      wait_done(100);
      repeat (20) @(negedge clk);
      chk("img_words", 24'(n_img), 24'd66048);
      chk("commit", 24'(n_commit), 24'h000001);
      chk("fw_active", {23'h0, fw_active}, 24'h000001);
      chk("ok_status", {16'h0, res_status}, 24'h000050);
      $display("test single done");
   endtask
   task automatic t_fail();
      clr();
      reload_ok = 1'b0;
      issue(8'h92, 8'h07, 16'h0001, 1'b0);
      feed(256);
      wait_done(100);
      chk("unc_err", {16'h0, res_error}, 24'h000040);
      chk("unc_status", {16'h0, res_status}, 24'h000051);
      chk("no_spin", 24'(n_spin), 24'h000000);
      reload_requested = 1'b0;
      issue(8'h92, 8'h07, 16'h0001, 1'b0);
      feed(256);
      wait_done(100);
      chk("noreq_err", {16'h0, res_error}, 24'h000000);
      reload_requested = 1'b1;
      reload_ok = 1'b1;
      $display("test reload_fail done");
   endtask
   task automatic t_offset();
      clr();
      spinup_disabled = 1'b1;
      seg(16'h0001, 1'b1);
      seg(16'h0001, 1'b0);
      issue(8'he7, 8'h00, 16'h0000, 1'b0);
      wait_done(50);
      chk("other_code", {16'h0, other_code}, 24'h0000e7);
      chk("other_n", 24'(n_other), 24'h000001);
      chk("other_drop", 24'(n_discard), 24'h000001);
      seg(16'h0001, 1'b1);
      issue(8'h92, 8'h03, 16'h0001, 1'b1);
      wait_done(50);
      chk("gap_err", {16'h0, res_error}, 24'h000004);
      chk("gap_drop", 24'(n_discard), 24'h000002);
      seg(16'h0002, 1'b1);
      chk("early_commit", 24'(n_commit), 24'h000000);
      seg(16'h0001, 1'b0);
      chk("final_commit", 24'(n_commit), 24'h000001);
      chk("spin_down", 24'(n_spin), 24'h000001);
      spinup_disabled = 1'b0;
      $display("test offset done");
   endtask
   task automatic t_soft();
      clr();
      seg(16'h0001, 1'b1);
      reset_req = 1'b1;
      @(negedge clk);
      reset_req = 1'b0;
      repeat (4) @(negedge clk);
      chk("reset_drop", 24'(n_discard), 24'h000001);
      chk("reset_status", {16'h0, link.status}, 24'h000050);
      seg(16'h0001, 1'b1);
      chk("reset_commit", 24'(n_commit), 24'h000000);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      seg(16'h0001, 1'b1);
      chk("hw_reset_err", {16'h0, res_error}, 24'h000000);
      $display("test soft_reset done");
   endtask
   initial begin
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      @(negedge clk);
      chk("rst_status", {16'h0, dev_st}, 24'h000050);
      chk("rst_error", {16'h0, dev_err}, 24'h000000);
      t_abort();
      t_single();
      t_fail();
      t_offset();
      t_soft();
      print_verdict();
   end
endmodule
`default_nettype wire
